// >>> core/cpuce_exec.sv
`timescale 1ns/10ps
`include "cpuce_params.svh"
module cpuce_exec (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rstn,
   input  wire logic                   i_start,
   input  wire cpuce_pkg::cpuce_cmd_type i_cmd,
   input  wire logic [7:0]             i_rdata,
   output logic                        o_busy,
   output logic                        o_done,
   output logic                        o_skip,
   output logic                        o_int_clr,
   output logic                        o_sio_start,
   output logic [15:0]                 o_pc,
   output logic [15:0]                 o_sp,
   output logic [7:0]                  o_psw,
   output logic [15:0]                 o_port_e,
   output logic                        o_port_e_addr_mode,
   output cpuce_pkg::cpuce_mem_type    o_mem
);
   typedef enum logic {ST_IDLE, ST_RUN} cpuce_state_type;

   function automatic logic [4:0] op_base(input cpuce_pkg::cpuce_op_type op);
      case (op)
         cpuce_pkg::CPUCE_OP_SKIP_NO_INT_FLAG: op_base = `CPUCE_CYC_SKIP;
         cpuce_pkg::CPUCE_OP_SIO_TRIGGER:      op_base = `CPUCE_CYC_SIO;
         cpuce_pkg::CPUCE_OP_CALL:             op_base = `CPUCE_CYC_CALL;
         cpuce_pkg::CPUCE_OP_RETI:             op_base = `CPUCE_CYC_RETI;
         cpuce_pkg::CPUCE_OP_PORT_E_EXPAND:    op_base = `CPUCE_CYC_EXPAND;
         cpuce_pkg::CPUCE_OP_PORT_E_ADDR_MODE: op_base = `CPUCE_CYC_ADDRMODE;
         default:                              op_base = `CPUCE_CYC_NOP;
      endcase
   endfunction : op_base

   function automatic logic [2:0] op_bytes(input cpuce_pkg::cpuce_op_type op);
      case (op)
         cpuce_pkg::CPUCE_OP_SKIP_NO_INT_FLAG,
         cpuce_pkg::CPUCE_OP_PORT_E_EXPAND,
         cpuce_pkg::CPUCE_OP_PORT_E_ADDR_MODE: op_bytes = `CPUCE_LEN_2;
         cpuce_pkg::CPUCE_OP_CALL:             op_bytes = `CPUCE_LEN_3;
         default:                              op_bytes = `CPUCE_LEN_1;
      endcase
   endfunction : op_bytes

   function automatic logic strobed(input logic [15:0] a);
      strobed = (a >= `CPUCE_STROBE_LO) && (a <= `CPUCE_STROBE_HI);
   endfunction : strobed

   cpuce_state_type          state_q;
   cpuce_pkg::cpuce_cmd_type cmd_q;
   cpuce_pkg::cpuce_mem_type mem_d;
   cpuce_pkg::cpuce_mem_type mem_q;
   logic [4:0]  cnt_q;
   logic [4:0]  len_q;
   logic        sup_q;
   logic        skip_q;
   logic        busy_q;
   logic        done_q;
   logic        int_clr_q;
   logic        sio_q;
   logic [15:0] pc_q;
   logic [15:0] sp_q;
   logic [7:0]  psw_q;
   logic [7:0]  pop_lo_q;
   logic [7:0]  pop_hi_q;
   logic [15:0] port_e_q;
   logic        amode_q;

   wire         accept   = i_start && (state_q == ST_IDLE);
   wire [4:0]   save_cyc = 5'(op_bytes(i_cmd.op)) * `CPUCE_FETCH_SAVE;
   wire [4:0]   len_d    = i_cmd.from_rom ? op_base(i_cmd.op)
                                          : op_base(i_cmd.op) - save_cyc;
   wire         running  = (state_q == ST_RUN);
   wire         last     = running && (cnt_q == len_q);
   wire         live     = running && !sup_q;
   wire         is_call  = live && (cmd_q.op == cpuce_pkg::CPUCE_OP_CALL);
   wire         is_reti  = live && (cmd_q.op == cpuce_pkg::CPUCE_OP_RETI);
   wire         is_pex   = live && (cmd_q.op == cpuce_pkg::CPUCE_OP_PORT_E_EXPAND);
   wire         is_per   = live &&
                           (cmd_q.op == cpuce_pkg::CPUCE_OP_PORT_E_ADDR_MODE);
   wire [15:0]  ret_addr = cmd_q.pc + 16'h0003;
   wire [15:0]  push_hi  = sp_q - 16'h0001;
   wire [15:0]  push_lo  = sp_q - 16'h0002;
   wire [15:0]  pop_a1   = sp_q + 16'h0001;
   wire [15:0]  pop_a2   = sp_q + 16'h0002;
   wire         wr_hi    = is_call && (cnt_q == `CPUCE_STEP_PUSH_HI);
   wire         wr_lo    = is_call && (cnt_q == `CPUCE_STEP_PUSH_LO);
   wire         rd_0     = is_reti && (cnt_q == `CPUCE_STEP_POP_0);
   wire         rd_1     = is_reti && (cnt_q == `CPUCE_STEP_POP_1);
   wire         rd_2     = is_reti && (cnt_q == `CPUCE_STEP_POP_2);
   wire [15:0]  acc_addr = wr_hi ? push_hi :
                           wr_lo ? push_lo :
                           rd_1  ? pop_a1  :
                           rd_2  ? pop_a2  : sp_q;
   wire         acc_rd   = rd_0 || rd_1 || rd_2;
   wire         acc_wr   = wr_hi || wr_lo;

   // strobes stay low for the internal rom region
   always_comb begin
      mem_d.addr  = acc_addr;
      mem_d.wdata = wr_hi ? ret_addr[15:8] : ret_addr[7:0];
      mem_d.rd    = acc_rd && strobed(acc_addr);
      mem_d.wr    = acc_wr && strobed(acc_addr);
   end

   wire         skip_set = accept && !skip_q &&
                           (i_cmd.op == cpuce_pkg::CPUCE_OP_SKIP_NO_INT_FLAG);
   wire [15:0]  next_pc  = cmd_q.pc + 16'(op_bytes(cmd_q.op));
   wire [15:0]  pc_d     = is_call ? cmd_q.target :
                           is_reti ? {pop_hi_q, pop_lo_q} : next_pc;
   wire         pex_latch = is_pex && (cnt_q == `CPUCE_STEP_LATCH);

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_IDLE;
         cmd_q   <= '0;
         cnt_q   <= 5'h00;
         len_q   <= 5'h00;
         sup_q   <= 1'b0;
      end else if (accept) begin
         state_q <= ST_RUN;
         cmd_q   <= i_cmd;
         cnt_q   <= 5'h01;
         len_q   <= len_d;
         sup_q   <= skip_q;
      end else if (last) begin
         state_q <= ST_IDLE;
      end else if (running) begin
         cnt_q   <= cnt_q + 5'h01;
      end
   end

   // skip decision is made as the flag-test instruction is taken
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         skip_q    <= 1'b0;
         int_clr_q <= 1'b0;
         sio_q     <= 1'b0;
      end else begin
         int_clr_q <= skip_set && i_cmd.int_flag;
         sio_q     <= accept && !skip_q &&
                      (i_cmd.op == cpuce_pkg::CPUCE_OP_SIO_TRIGGER);
         if (accept) begin
            skip_q <= skip_set && !i_cmd.int_flag;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         mem_q    <= '0;
         pc_q     <= `CPUCE_PC_RESET;
         sp_q     <= `CPUCE_SP_RESET;
         psw_q    <= 8'h00;
         pop_lo_q <= 8'h00;
         pop_hi_q <= 8'h00;
      end else begin
         busy_q <= accept || (running && !last);
         done_q <= last;
         mem_q  <= mem_d;
         if (is_reti && cnt_q == `CPUCE_STEP_GET_0) pop_lo_q <= i_rdata;
         if (is_reti && cnt_q == `CPUCE_STEP_GET_1) pop_hi_q <= i_rdata;
         if (is_reti && cnt_q == `CPUCE_STEP_GET_2) psw_q <= i_rdata;
         if (last) begin
            pc_q <= pc_d;
            if (is_call) sp_q <= push_lo;
            if (is_reti) sp_q <= sp_q + 16'h0003;
         end
      end
   end

   // port e keeps its latch until the next expand or address-mode
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         port_e_q <= 16'h0000;
         amode_q  <= 1'b0;
      end else if (pex_latch) begin
         port_e_q <= {cmd_q.reg_b, cmd_q.reg_c};
         amode_q  <= 1'b0;
      end else if (is_per && last) begin
         amode_q  <= 1'b1;
      end else if (amode_q && (mem_d.rd || mem_d.wr)) begin
         port_e_q <= mem_d.addr;
      end
   end

   assign o_busy             = busy_q;
   assign o_done             = done_q;
   assign o_skip             = skip_q;
   assign o_int_clr          = int_clr_q;
   assign o_sio_start        = sio_q;
   assign o_pc               = pc_q;
   assign o_sp               = sp_q;
   assign o_psw              = psw_q;
   assign o_port_e           = port_e_q;
   assign o_port_e_addr_mode = amode_q;
   assign o_mem              = mem_q;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   rom_call_len_a: assert property (
      accept && i_cmd.op == cpuce_pkg::CPUCE_OP_CALL && i_cmd.from_rom
      |=> (len_q == 5'd22))
      else $error("call from rom not 22 cycles");
   ext_len_a: assert property (
      accept && !i_cmd.from_rom && i_cmd.op == cpuce_pkg::CPUCE_OP_RETI
      |=> (len_q == 5'd14))
      else $error("return from external not 14 cycles");
   skip_flag_a: assert property (
      accept && !skip_q && i_cmd.int_flag &&
      i_cmd.op == cpuce_pkg::CPUCE_OP_SKIP_NO_INT_FLAG
      |=> o_int_clr && !o_skip)
      else $error("set flag not cleared or skip taken");
   sio_pulse_a: assert property (
      $rose(o_sio_start) |-> $past(accept) && !sup_q &&
      cmd_q.op == cpuce_pkg::CPUCE_OP_SIO_TRIGGER)
      else $error("serial start without trigger");
   call_push_a: assert property (
      wr_hi |=> o_mem.addr == push_hi + 16'h0000 ##0
      o_mem.wdata == ret_addr[15:8])
      else $error("call high byte push wrong");
   reti_sp_a: assert property (
      is_reti && last |=> o_sp == $past(sp_q) + 16'h0003)
      else $error("return did not raise stack by three");
   port_hold_a: assert property (
      !pex_latch && !amode_q |=> $stable(o_port_e))
      else $error("port e latch changed");
   strobe_range_a: assert property (
      (o_mem.rd || o_mem.wr) |-> o_mem.addr >= 16'h1000 &&
      o_mem.addr <= 16'hff7f)
      else $error("strobe outside window");
   skip_quiet_a: assert property (
      running && sup_q |-> !o_mem.rd && !o_mem.wr ##1 !o_sio_start)
      else $error("skipped instruction had effect");

   call_c: cover property (is_call && last);
   reti_c: cover property (is_reti && last);
   skip_c: cover property (running && sup_q && last);
   pex_c:  cover property (pex_latch);
endmodule : cpuce_exec

// >>> core/cpuce_params.svh
`ifndef CPUCE_PARAMS_SVH
`define CPUCE_PARAMS_SVH
// Summary of operation
// - code fetched outside internal rom runs two cycles shorter per opcode byte.
// - flag-test skip skips next when flag clear, clears flag when set; 12 cycles.
// - serial trigger instruction starts a serial transfer; 9 cycles.
// - call pushes (pc+3) high at sp-1, low at sp-2, loads target; 22 cycles.
// - interrupt return pops pc low, pc high, status word, sp plus three; 16.
// - expand copies b to port e high bits, c to low bits at latch state.
// - port e latch holds until next expand or address-mode instruction.
// - read and write strobes only for addresses 1000h through ff7fh.

// cycle counts as seen when running from internal rom
`define CPUCE_CYC_SKIP     5'd12
`define CPUCE_CYC_SIO      5'd9
`define CPUCE_CYC_CALL     5'd22
`define CPUCE_CYC_RETI     5'd16
`define CPUCE_CYC_EXPAND   5'd15
`define CPUCE_CYC_ADDRMODE 5'd12
`define CPUCE_CYC_NOP      5'd9
// reduction per fetched opcode byte when fetched outside internal rom
`define CPUCE_FETCH_SAVE   5'd2
// opcode byte counts
`define CPUCE_LEN_1        3'd1
`define CPUCE_LEN_2        3'd2
`define CPUCE_LEN_3        3'd3
// step numbers inside an instruction (counter starts at 1)
`define CPUCE_STEP_PUSH_HI 5'd2
`define CPUCE_STEP_PUSH_LO 5'd3
`define CPUCE_STEP_POP_0   5'd2
`define CPUCE_STEP_POP_1   5'd3
`define CPUCE_STEP_POP_2   5'd4
`define CPUCE_STEP_GET_0   5'd4
`define CPUCE_STEP_GET_1   5'd5
`define CPUCE_STEP_GET_2   5'd6
// third machine cycle, first state
`define CPUCE_STEP_LATCH   5'd6
// strobed address window
`define CPUCE_STROBE_LO    16'h1000
`define CPUCE_STROBE_HI    16'hff7f
// reset values
`define CPUCE_SP_RESET     16'h0000
`define CPUCE_PC_RESET     16'h0000
`endif

// >>> core/cpuce_pkg.sv
package cpuce_pkg;
   typedef enum logic [2:0] {
      CPUCE_OP_NOP,
      CPUCE_OP_SKIP_NO_INT_FLAG,
      CPUCE_OP_SIO_TRIGGER,
      CPUCE_OP_CALL,
      CPUCE_OP_RETI,
      CPUCE_OP_PORT_E_EXPAND,
      CPUCE_OP_PORT_E_ADDR_MODE
   } cpuce_op_type;

   typedef struct packed {
      cpuce_op_type op;
      logic         from_rom;
      logic         int_flag;
      logic [15:0]  pc;
      logic [15:0]  target;
      logic [7:0]   reg_b;
      logic [7:0]   reg_c;
   } cpuce_cmd_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        rd;
      logic        wr;
   } cpuce_mem_type;
endpackage : cpuce_pkg

// >>> testbench/cpuce_mem_model.sv
`timescale 1ns/10ps
module cpuce_mem_model (
   input  wire logic                     i_sys_clk,
   input  wire cpuce_pkg::cpuce_mem_type i_mem,
   output logic [7:0]                    o_rdata
);
   logic [7:0] mem_q [0:65535];
   logic [7:0] last_q = 8'h5a;
   logic       valid_q = 1'b0;
   // read data stands one cycle after the strobe; an idle bus shows the
   // inverse of the last byte, never a stale copy
   assign o_rdata = valid_q ? last_q : ~last_q;
   always @(posedge i_sys_clk) begin
      if (i_mem.wr) begin
         mem_q[i_mem.addr] <= i_mem.wdata;
      end
      valid_q <= i_mem.rd;
      if (i_mem.rd) begin
         last_q <= mem_q[i_mem.addr];
      end
   end
endmodule : cpuce_mem_model

// >>> testbench/tb.sv
`timescale 1ns/10ps
module tb;
   logic                     i_sys_clk = 1'b0;
   logic                     i_rstn = 1'b0;
   logic                     i_start = 1'b0;
   cpuce_pkg::cpuce_cmd_type i_cmd = '0;
   logic [7:0]               i_rdata;
   logic                     o_busy, o_done, o_skip, o_int_clr;
   logic                     o_sio_start, o_port_e_addr_mode;
   logic [15:0]              o_pc, o_sp, o_port_e;
   logic [7:0]               o_psw;
   cpuce_pkg::cpuce_mem_type o_mem;
   logic                     seen_clr, seen_sio, seen_mem, seen_busy;
   logic [15:0]              pe_at [40];
   int                       cyc;
   int                       n_mismatch = 0;
   int                       samples_checked = 0;

   cpuce_exec i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .i_start(i_start), .i_cmd(i_cmd), .i_rdata(i_rdata),
      .o_busy(o_busy), .o_done(o_done), .o_skip(o_skip),
      .o_int_clr(o_int_clr), .o_sio_start(o_sio_start), .o_pc(o_pc),
      .o_sp(o_sp), .o_psw(o_psw), .o_port_e(o_port_e),
      .o_port_e_addr_mode(o_port_e_addr_mode), .o_mem(o_mem));
   cpuce_mem_model u_mem (.i_sys_clk(i_sys_clk), .i_mem(o_mem),
      .o_rdata(i_rdata));

   initial begin
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // strobes outside the external window are never allowed
   always @(posedge i_sys_clk) begin
      if (i_rstn && (o_mem.rd || o_mem.wr) && (o_mem.addr < 16'h1000 ||
          o_mem.addr > 16'hff7f)) begin
         n_mismatch++;
         $display("[ERR] %0t strobe at %h", $time, o_mem.addr);
      end
   end

   task automatic exec();
      i_start = 1'b1;
      @(posedge i_sys_clk);
      #1;
      i_start = 1'b0;
      {seen_clr, seen_sio, seen_mem, seen_busy} = {o_int_clr, o_sio_start,
         o_mem.rd | o_mem.wr, o_busy};
      for (cyc = 1; cyc < 40; cyc++) begin
         @(posedge i_sys_clk);
         #1;
         seen_clr |= o_int_clr;
         seen_sio |= o_sio_start;
         seen_mem |= o_mem.rd | o_mem.wr;
         seen_busy |= o_busy;
         pe_at[cyc] = o_port_e;
         if (o_done === 1'b1) break;
      end
   endtask : exec

   task automatic t_stack();
      i_cmd.op = cpuce_pkg::CPUCE_OP_CALL;
      i_cmd.from_rom = 1'b1;
      for (int k = 0; k < 64; k++) begin
         exec();
         chk(16'(seen_mem), 16'h0000);
         chk(16'(cyc), 16'd22);
      end
      chk(o_sp, 16'hff80);
      i_cmd.from_rom = 1'b0;
      i_cmd.pc = 16'h1234;
      i_cmd.target = 16'h2000;
      exec();
      chk(16'(cyc), 16'd16);
      chk(o_pc, 16'h2000);
      chk({8'h00, u_mem.mem_q[16'hff7f]}, 16'h0012);
      chk({8'h00, u_mem.mem_q[16'hff7e]}, 16'h0037);
      i_cmd.pc = 16'h2000;
      i_cmd.target = 16'h3000;
      exec();
      chk(o_sp, 16'hff7c);
      i_cmd.op = cpuce_pkg::CPUCE_OP_RETI;
      i_cmd.from_rom = 1'b1;
      exec();
      chk(16'(cyc), 16'd16);
      chk(o_pc, 16'h2003);
      chk(o_sp, 16'hff7f);
      chk({8'h00, o_psw}, 16'h0037);
      $display("stack test done");
   endtask : t_stack

   task automatic t_timing();
      int base_c[7] = '{9, 12, 9, 22, 16, 15, 12};
      int len_b[7] = '{1, 2, 1, 3, 1, 2, 2};
      for (int k = 0; k < 14; k++) begin
         i_cmd.op = cpuce_pkg::cpuce_op_type'(k / 2);
         i_cmd.from_rom = k[0];
         i_cmd.int_flag = 1'b1;
         exec();
         chk(16'(cyc),
             16'(base_c[k / 2] - (k[0] ? 0 : 2 * len_b[k / 2])));
      end
      $display("timing test done");
   endtask : t_timing

   task automatic t_skip();
      i_cmd.op = cpuce_pkg::CPUCE_OP_SKIP_NO_INT_FLAG;
      i_cmd.from_rom = 1'b1;
      exec();
      chk(16'({seen_clr, o_skip}), 16'h0002);
      i_cmd.int_flag = 1'b0;
      exec();
      chk(16'({seen_clr, o_skip}), 16'h0001);
      i_cmd.op = cpuce_pkg::CPUCE_OP_CALL;
      i_cmd.pc = 16'h0300;
      i_cmd.target = 16'h4000;
      exec();
      chk(16'({seen_mem, o_skip}), 16'h0000);
      chk(o_pc, 16'h0303);
      chk(o_sp, 16'hff81);
      $display("skip test done");
   endtask : t_skip

   task automatic t_port();
      i_cmd.op = cpuce_pkg::CPUCE_OP_PORT_E_EXPAND;
      i_cmd.reg_b = 8'ha5;
      i_cmd.reg_c = 8'h3c;
      exec();
      chk({o_port_e[15:1], o_port_e_addr_mode}, 16'ha53c);
      i_cmd.reg_b = 8'h5a;
      i_cmd.reg_c = 8'hc3;
      exec();
      chk(pe_at[5], 16'ha53c);
      chk(pe_at[6], 16'h5ac3);
      i_cmd.op = cpuce_pkg::CPUCE_OP_SIO_TRIGGER;
      exec();
      chk(16'(seen_sio), 16'h0001);
      chk({7'h00, seen_busy, 7'h00, o_busy}, 16'h0100);
      chk(o_port_e, 16'h5ac3);
      i_cmd.op = cpuce_pkg::CPUCE_OP_PORT_E_ADDR_MODE;
      exec();
      chk(16'(o_port_e_addr_mode), 16'h0001);
      i_cmd.op = cpuce_pkg::CPUCE_OP_CALL;
      exec();
      chk(o_port_e, 16'hff7f);
      chk(o_sp, 16'hff7f);
      $display("port test done");
   endtask : t_port

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #100000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge i_sys_clk);
      #1;
      i_rstn = 1'b1;
      chk(o_sp, 16'h0000);
      chk(o_pc, 16'h0000);
      t_stack();
      t_timing();
      t_skip();
      t_port();
      tally_and_finish();
   end
endmodule : tb
